// [rtl/tbs_pkg.sv]
// Package holding constants and types for the boundary-scan test access port.
package tbs_pkg;

    // ------------------------------------------------------------------
    // Register sizes
    // ------------------------------------------------------------------
    localparam int IR_W  = 8;   // Instruction register length.
    localparam int BSR_W = 80;  // Boundary chain length.
    localparam int ID_W  = 32;  // Identification register length.

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_EXTEST     = 8'h00;
    localparam logic [IR_W-1:0] IR_SAMPLE     = 8'h81;
    localparam logic [IR_W-1:0] IR_CLAMP      = 8'h82;
    localparam logic [IR_W-1:0] IR_HIGHZ      = 8'h03;
    localparam logic [IR_W-1:0] IR_SAMPLE_IN  = 8'h41;
    localparam logic [IR_W-1:0] IR_SAMPLE_OUT = 8'h42;
    localparam logic [IR_W-1:0] IR_EXTEST_OUT = 8'h22;
    localparam logic [IR_W-1:0] IR_IDCODE     = 8'haa;
    localparam logic [IR_W-1:0] IR_BYPASS     = 8'hff;
    localparam logic [IR_W-1:0] IR_CAPTURE    = 8'h81; // Low two bits are 01.
    localparam logic [IR_W-1:0] IR_RESET      = IR_BYPASS;

    // ------------------------------------------------------------------
    // Boundary chain field positions and reset values
    // ------------------------------------------------------------------
    localparam int BSR_A_OUT_LSB = 0;
    localparam int BSR_B_IN_LSB  = 18;
    localparam int BSR_B_OUT_LSB = 36;
    localparam int BSR_A_IN_LSB  = 54;
    localparam int BSR_B_EN2_BIT = 72;
    localparam int BSR_A_EN2_BIT = 73;
    localparam int BSR_B_EN1_BIT = 76;
    localparam int BSR_A_EN1_BIT = 77;
    localparam logic [BSR_W-1:0] BSR_RESET = 80'h0;
    localparam logic [2:0]       TMS_RESET_CLKS = 3'h5;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        TBS_TLR, TBS_IDLE, TBS_SEL_DR, TBS_CAP_DR, TBS_SHIFT_DR, TBS_EXIT1_DR,
        TBS_PAUSE_DR, TBS_EXIT2_DR, TBS_UPD_DR, TBS_SEL_IR, TBS_CAP_IR,
        TBS_SHIFT_IR, TBS_EXIT1_IR, TBS_PAUSE_IR, TBS_EXIT2_IR, TBS_UPD_IR
    } tbs_state_t;

    typedef enum logic [1:0] {TBS_PICK_BYP, TBS_PICK_BSR, TBS_PICK_ID} tbs_pick_t;

    // Test pins from the tester.
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tbs_tap_in_t;

    // Serial data out with its drive enable.
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } tbs_tap_out_t;

    // Boundary cells, MSB first, so that the packed value is chain order.
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [17:0] a_in;
        logic [17:0] b_out;
        logic [17:0] b_in;
        logic [17:0] a_out;
    } tbs_cells_t;

endpackage : tbs_pkg

// [rtl/tbs_tap.sv]
// Test access port controller, instruction register and boundary chain.
`timescale 1ns/100ps

// Operation
// - Chain order: A out, B in, B out.
// - Four test pins; power-up reset only.
// - State holds while test clock stopped.
// - Mode select sampled on rising edge.
// - Data-in sampled on rise, appears uninverted.
// - Data-out changes only on falling edge.
// - Data-out driven only while shifting.
// - State changes only on rise or reset.
// - Five high mode clocks reach reset.
// - Low glitch returns via idle, selects.
// - Test logic disabled in reset state.
// - Idle performs no test activity.
// - Capture-DR loads selected register only.
// - Shift-DR advances selected register only.
// - DR select, exit, pause states hold.
// - Update-DR latches chain on falling edge.
// - Capture-IR loads low bits 01.
// - Shift-IR shifts instruction, drives out.
// - IR select, exit, pause states hold.
// - Update-IR latches instruction on falling edge.
// - State actions follow the entering edge.
// - Eight-bit instruction codes and decode.
// - Bypass stage captures zero.
// - Enable cells enable on logic one.
module tbs_tap
    import tbs_pkg::*;
#(
    parameter logic [ID_W-1:0] ID_CODE = 32'h1234_5679 // Arbitrary value.
)(
    // Clock and power-up reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst,
    // Test pins and system pin observation
    input  wire tbs_tap_in_t  i_tap,
    input  wire tbs_cells_t   i_sys_obs,
    // Test data out
    output tbs_tap_out_t      o_tap,
    // Boundary latches towards the transceiver
    output tbs_cells_t        o_cells,
    output logic [1:0]        o_side_a_output_enable,
    output logic [1:0]        o_side_b_output_enable,
    output logic              o_cells_drive,
    output logic              o_force_highz,
    output logic [IR_W-1:0]   o_cur_instr
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Standard controller graph; tms chooses the branch.
    function automatic tbs_state_t tbs_step(input tbs_state_t s, input logic tms);
        case (s)
            TBS_TLR:      tbs_step = tms ? TBS_TLR      : TBS_IDLE;
            TBS_IDLE:     tbs_step = tms ? TBS_SEL_DR   : TBS_IDLE;
            TBS_SEL_DR:   tbs_step = tms ? TBS_SEL_IR   : TBS_CAP_DR;
            TBS_CAP_DR:   tbs_step = tms ? TBS_EXIT1_DR : TBS_SHIFT_DR;
            TBS_SHIFT_DR: tbs_step = tms ? TBS_EXIT1_DR : TBS_SHIFT_DR;
            TBS_EXIT1_DR: tbs_step = tms ? TBS_UPD_DR   : TBS_PAUSE_DR;
            TBS_PAUSE_DR: tbs_step = tms ? TBS_EXIT2_DR : TBS_PAUSE_DR;
            TBS_EXIT2_DR: tbs_step = tms ? TBS_UPD_DR   : TBS_SHIFT_DR;
            TBS_UPD_DR:   tbs_step = tms ? TBS_SEL_DR   : TBS_IDLE;
            TBS_SEL_IR:   tbs_step = tms ? TBS_TLR      : TBS_CAP_IR;
            TBS_CAP_IR:   tbs_step = tms ? TBS_EXIT1_IR : TBS_SHIFT_IR;
            TBS_SHIFT_IR: tbs_step = tms ? TBS_EXIT1_IR : TBS_SHIFT_IR;
            TBS_EXIT1_IR: tbs_step = tms ? TBS_UPD_IR   : TBS_PAUSE_IR;
            TBS_PAUSE_IR: tbs_step = tms ? TBS_EXIT2_IR : TBS_PAUSE_IR;
            TBS_EXIT2_IR: tbs_step = tms ? TBS_UPD_IR   : TBS_SHIFT_IR;
            TBS_UPD_IR:   tbs_step = tms ? TBS_SEL_DR   : TBS_IDLE;
            default:      tbs_step = TBS_TLR;
        endcase
    endfunction : tbs_step

    // Data register chosen by an instruction; unknown codes pick bypass.
    function automatic tbs_pick_t tbs_pick(input logic [IR_W-1:0] ir);
        case (ir)
            IR_EXTEST, IR_SAMPLE, IR_SAMPLE_IN, IR_SAMPLE_OUT, IR_EXTEST_OUT:
                tbs_pick = TBS_PICK_BSR;
            IR_IDCODE: tbs_pick = TBS_PICK_ID;
            default:   tbs_pick = TBS_PICK_BYP;
        endcase
    endfunction : tbs_pick

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    tbs_tap_in_t tap_s1_reg;   // First stage, read only by the second.
    tbs_tap_in_t tap_s2_reg;   // Safe copy of the test pins.
    logic        tck_d_reg;    // Delayed clock level for edge detection.
    tbs_cells_t  obs_s1_reg;   // First stage of system pin sampling.
    tbs_cells_t  obs_s2_reg;   // Safe copy of the system pins.
    logic        tck_rise;     // One cycle per rising test clock edge.
    logic        tck_fall;     // One cycle per falling test clock edge.

    // The pull-ups on mode select and data-in live in the pad; an open pin
    // arrives here already high, so nothing further is needed.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            tap_s1_reg <= '0;
            tap_s2_reg <= '0;
            tck_d_reg  <= 1'b0;
            obs_s1_reg <= '0;
            obs_s2_reg <= '0;
        end
        else
        begin
            tap_s1_reg <= i_tap;
            tap_s2_reg <= tap_s1_reg;
            tck_d_reg  <= tap_s2_reg.tck;
            obs_s1_reg <= i_sys_obs;
            obs_s2_reg <= obs_s1_reg;
        end
    end

    // No edge means no change anywhere, whatever level the clock stops at.
    assign tck_rise = tap_s2_reg.tck & ~tck_d_reg;
    assign tck_fall = ~tap_s2_reg.tck & tck_d_reg;

    // ------------------------------------------------------------------
    // Controller and registers
    // ------------------------------------------------------------------
    tbs_state_t       state_reg,    state_next;    // Controller state.
    logic [IR_W-1:0]  ir_sh_reg,    ir_sh_next;    // Instruction shift stages.
    logic [IR_W-1:0]  ir_lat_reg,   ir_lat_next;   // Active instruction.
    logic             byp_reg,      byp_next;      // Bypass stage.
    logic [BSR_W-1:0] bsr_reg,      bsr_next;      // Boundary shift stages.
    logic [BSR_W-1:0] upd_reg,      upd_next;      // Boundary output latches.
    logic [ID_W-1:0]  id_reg,       id_next;       // Identification stages.
    logic             tdo_reg,      tdo_next;      // Serial data out.
    logic             oe_reg,       oe_next;       // Serial out drive enable.
    logic             drive_reg,    drive_next;    // Cells own the outputs.
    logic             highz_reg,    highz_next;    // Outputs forced off.
    tbs_pick_t        pick;                        // Data register in use.

    assign pick = tbs_pick(ir_lat_reg);

    // Rising edges move the controller and shift; falling edges update
    // latches and the serial output, so the next device sees no race.
    always_comb
    begin
        state_next  = state_reg;
        ir_sh_next  = ir_sh_reg;
        ir_lat_next = ir_lat_reg;
        byp_next    = byp_reg;
        bsr_next    = bsr_reg;
        upd_next    = upd_reg;
        id_next     = id_reg;
        tdo_next    = tdo_reg;
        oe_next     = oe_reg;
        if (tck_rise)
        begin
            // Mode select and data-in are taken only at this edge.
            state_next = tbs_step(state_reg, tap_s2_reg.tms);
            // Each action belongs to the state entered at the edge before.
            case (state_reg)
                TBS_CAP_IR:
                    ir_sh_next = IR_CAPTURE;
                TBS_SHIFT_IR:
                    ir_sh_next = {tap_s2_reg.tdi, ir_sh_reg[IR_W-1:1]};
                TBS_CAP_DR:
                begin
                    // Only the selected register loads.
                    case (pick)
                        TBS_PICK_BYP: byp_next = 1'b0;
                        TBS_PICK_BSR: bsr_next = obs_s2_reg;
                        TBS_PICK_ID:  id_next  = ID_CODE;
                        default:      byp_next = 1'b0;
                    endcase
                end
                TBS_SHIFT_DR:
                begin
                    // Bit 0 sits next to data-out; data-in enters at the top.
                    case (pick)
                        TBS_PICK_BYP: byp_next = tap_s2_reg.tdi;
                        TBS_PICK_BSR: bsr_next = {tap_s2_reg.tdi, bsr_reg[BSR_W-1:1]};
                        TBS_PICK_ID:  id_next  = {tap_s2_reg.tdi, id_reg[ID_W-1:1]};
                        default:      byp_next = tap_s2_reg.tdi;
                    endcase
                end
                // Idle, selects, exits and pauses hold every register.
                default: ;
            endcase
        end
        if (tck_fall)
        begin
            case (state_reg)
                TBS_UPD_IR:
                    ir_lat_next = ir_sh_reg;
                TBS_TLR:
                    ir_lat_next = IR_RESET;
                TBS_UPD_DR:
                begin
                    if (pick == TBS_PICK_BSR)
                    begin
                        upd_next = bsr_reg;
                    end
                end
                default: ;
            endcase
            // Drive only while shifting so shared data-out wires never fight.
            oe_next = (state_reg == TBS_SHIFT_IR) || (state_reg == TBS_SHIFT_DR);
            if (state_reg == TBS_SHIFT_IR)
            begin
                tdo_next = ir_sh_reg[0];
            end
            else
            begin
                case (pick)
                    TBS_PICK_BSR: tdo_next = bsr_reg[0];
                    TBS_PICK_ID:  tdo_next = id_reg[0];
                    default:      tdo_next = byp_reg;
                endcase
            end
        end
        // Reset state hands the pins back to the transceiver.
        drive_next = (state_reg != TBS_TLR) && ((ir_lat_reg == IR_EXTEST) ||
                     (ir_lat_reg == IR_CLAMP) || (ir_lat_reg == IR_EXTEST_OUT));
        highz_next = (state_reg != TBS_TLR) && (ir_lat_reg == IR_HIGHZ);
    end

    // Power-up reset is the only reset; no test reset pin exists.
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            state_reg  <= TBS_TLR;
            ir_sh_reg  <= IR_CAPTURE;
            ir_lat_reg <= IR_RESET;
            byp_reg    <= 1'b0;
            bsr_reg    <= BSR_RESET;
            upd_reg    <= BSR_RESET;
            id_reg     <= '0;
            tdo_reg    <= 1'b0;
            oe_reg     <= 1'b0;
            drive_reg  <= 1'b0;
            highz_reg  <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            ir_sh_reg  <= ir_sh_next;
            ir_lat_reg <= ir_lat_next;
            byp_reg    <= byp_next;
            bsr_reg    <= bsr_next;
            upd_reg    <= upd_next;
            id_reg     <= id_next;
            tdo_reg    <= tdo_next;
            oe_reg     <= oe_next;
            drive_reg  <= drive_next;
            highz_reg  <= highz_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_tap.tdo     = tdo_reg;
    assign o_tap.tdo_oe  = oe_reg;
    assign o_cells       = upd_reg;
    assign o_cells_drive = drive_reg;
    assign o_force_highz = highz_reg;
    assign o_cur_instr   = ir_lat_reg;
    // Internal enable cells turn their side on when they hold a one.
    assign o_side_a_output_enable = {upd_reg[BSR_A_EN1_BIT], upd_reg[BSR_A_EN2_BIT]};
    assign o_side_b_output_enable = {upd_reg[BSR_B_EN1_BIT], upd_reg[BSR_B_EN2_BIT]};

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [2:0] tms_ones_reg; // Consecutive rising edges seen with mode select high.

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            tms_ones_reg <= 3'h0;
        end
        else if (tck_rise)
        begin
            tms_ones_reg <= !tap_s2_reg.tms ? 3'h0 :
                            (tms_ones_reg == 3'h7) ? 3'h7 : tms_ones_reg + 3'h1;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    a_five_tms_reset: assert property (
        tms_ones_reg >= TMS_RESET_CLKS |-> state_reg == TBS_TLR)
        else $error("Controller not in reset after five high mode clocks.");
    a_state_no_edge: assert property (
        !tck_rise |=> $stable(state_reg))
        else $error("Controller moved without a rising test clock edge.");
    a_tdo_falling_only: assert property (
        ($changed(tdo_reg) || $changed(oe_reg)) |-> $past(tck_fall))
        else $error("Data-out changed away from a falling edge.");
    a_tdo_oe_shift: assert property (
        tck_fall |=> oe_reg == ($past(state_reg) inside {TBS_SHIFT_IR, TBS_SHIFT_DR}))
        else $error("Data-out enable wrong for the shifting state.");
    a_ir_capture_val: assert property (
        tck_rise && state_reg == TBS_CAP_IR |=> ir_sh_reg[1:0] == 2'b01)
        else $error("Instruction capture did not load 01.");
    a_bypass_capture: assert property (
        tck_rise && state_reg == TBS_CAP_DR && pick == TBS_PICK_BYP |=> !byp_reg)
        else $error("Bypass stage did not capture zero.");
    a_ir_update_fall: assert property (
        tck_fall && state_reg == TBS_UPD_IR |=> ir_lat_reg == $past(ir_sh_reg))
        else $error("Instruction latch missed update.");
    a_reset_no_drive: assert property (
        state_reg == TBS_TLR [*2] |-> !drive_reg && !highz_reg)
        else $error("Boundary cells active in reset state.");
    a_ir_hold_states: assert property (
        tck_rise && state_reg inside {TBS_SEL_IR, TBS_EXIT1_IR, TBS_PAUSE_IR, TBS_EXIT2_IR}
        |=> $stable(ir_sh_reg))
        else $error("Instruction stages changed in a hold state.");
    a_bsr_hold_states: assert property (
        tck_rise && state_reg inside {TBS_SEL_DR, TBS_EXIT1_DR, TBS_PAUSE_DR, TBS_EXIT2_DR}
        |=> $stable(bsr_reg) && $stable(byp_reg) && $stable(id_reg))
        else $error("Data registers changed in a hold state.");
    a_glitch_to_idle: assert property (
        tck_rise && state_reg == TBS_TLR && !tap_s2_reg.tms |=> state_reg == TBS_IDLE)
        else $error("Low mode select in reset state did not lead to idle.");

endmodule : tbs_tap

// [testbench/tbs_tap_tb.sv]
// Self-checking testbench for the test access port and boundary chain.
`timescale 1ns/100ps

module tbs_tap_tb;
    import tbs_pkg::*;

    // ------------------------------------------------------------------
    // Signals and expectation queue
    // ------------------------------------------------------------------
    localparam logic [ID_W-1:0] TB_ID = 32'h5a3c_96e3; // Arbitrary value, bit 0 set.
    typedef struct packed { logic oe; logic chk; logic d; } tbs_exp_t;

    logic              i_sys_clk = 1'b0;   // System clock, 4 ns period.
    logic              i_rst     = 1'b1;   // Power-up reset.
    tbs_cells_t        sys_obs   = '0;     // Levels seen by the cells.
    tbs_tap_in_t       tap_in;             // Test pins from the tester.
    tbs_tap_out_t      tap_out;            // Serial output of the device.
    tbs_cells_t        cells;              // Update latches.
    logic [1:0]        a_en;               // Side A enable latches.
    logic [1:0]        b_en;               // Side B enable latches.
    logic              drive;              // Latches own the pins.
    logic              highz;              // All pins forced off.
    logic [IR_W-1:0]   cur_instr;          // Active instruction.
    logic              seen;               // Tester finished a test clock.
    tbs_tap_out_t      early;              // Output before the rise.
    tbs_tap_out_t      late;               // Output before the fall.
    tbs_exp_t          exp_q[$];           // Expected output per test clock.
    tbs_exp_t          e;                  // Note being compared.
    int                error_cnt   = 0;    // Mismatches seen.
    int                checks_done = 0;    // Comparisons made.

    always #2 i_sys_clk = ~i_sys_clk;

    tbs_tap #(.ID_CODE(TB_ID)) uut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_tap(tap_in), .i_sys_obs(sys_obs),
        .o_tap(tap_out), .o_cells(cells), .o_side_a_output_enable(a_en),
        .o_side_b_output_enable(b_en), .o_cells_drive(drive), .o_force_highz(highz),
        .o_cur_instr(cur_instr));

    tbs_tester_model tester (
        .i_sys_clk(i_sys_clk), .i_tap_out(tap_out), .o_tap_in(tap_in), .o_seen(seen),
        .o_before_rise(early), .o_before_fall(late));

    // ------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------
    task automatic check(input logic [79:0] got, input logic [79:0] want, input string what);
        checks_done++;
        if (got !== want)
        begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check

    task automatic report_and_stop();
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // Each finished test clock takes the oldest note and compares what the tester saw.
    always @(posedge i_sys_clk)
    begin
        if (seen === 1'b1)
        begin
            e = exp_q.pop_front();
            check(80'(early.tdo_oe), 80'(e.oe), "output drive");
            if (e.chk === 1'b1)
                check(80'(early.tdo), 80'(e.d), "serial bit");
            check(80'(late), 80'(early), "output moved while clock high");
        end
    end

    // A hang is cut short well inside the cycle budget.
    initial
    begin
        repeat (90000) @(posedge i_sys_clk);
        error_cnt++;
        $display("unexpected at %0t: run did not finish", $time);
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------------
    task automatic step(input logic tms, input logic tdi, input logic oe, input logic chk,
                        input logic d);
        exp_q.push_back('{oe: oe, chk: chk, d: d});
        tester.tck_cycle(tms, tdi);
    endtask : step

    // A test clock outside the shift states, where the output must stay off.
    task automatic quiet(input logic tms);
        step(tms, 1'b1, 1'b0, 1'b0, 1'b0);
    endtask : quiet

    // Full scan from idle back to idle; a pause detour follows bit pause_at if it is in range.
    task automatic scan(input logic is_ir, input int n, input logic [79:0] din,
                        input logic [79:0] dout, input int pause_at);
        quiet(1'b1);
        if (is_ir)
            quiet(1'b1);
        quiet(1'b0);
        quiet(1'b0);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1 || i == pause_at, din[i], 1'b1, 1'b1, dout[i]);
            if (i == pause_at)
            begin
                // Exit1, pause twice, exit2, back to shift: nothing may move meanwhile.
                quiet(1'b0);
                quiet(1'b0);
                quiet(1'b1);
                quiet(1'b0);
            end
        end
        quiet(1'b1);
        quiet(1'b0);
    endtask : scan

    // Loads an instruction; the capture value comes out first.
    task automatic load_ir(input logic [IR_W-1:0] code, input int pause_at);
        scan(1'b1, IR_W, 80'(code), 80'(IR_CAPTURE), pause_at);
        check(80'(cur_instr), 80'(code), "instruction latch");
    endtask : load_ir

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    logic [IR_W-1:0] codes[9];
    logic [IR_W-1:0] code;
    logic [79:0]     din;
    logic [79:0]     held;
    logic            is_bsr;

    initial
    begin
        void'($urandom(88));
        repeat (16) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (8) @(posedge i_sys_clk);
        check(80'(cur_instr), 80'(IR_RESET), "instruction after reset");
        check(80'({drive, highz, a_en, b_en, tap_out}), 80'h0, "outputs after reset");
        check(80'(cells), 80'(BSR_RESET), "cells after reset");
        // Low glitch from the reset state must wander back to it.
        quiet(1'b0);
        quiet(1'b1);
        quiet(1'b1);
        quiet(1'b1);
        quiet(1'b0);
        load_ir(IR_IDCODE, 3);
        din = 80'({$urandom, $urandom});
        scan(1'b0, ID_W, din, 80'(TB_ID), 20);
        // Five high mode clocks from inside a data shift reach the reset state.
        quiet(1'b1);
        quiet(1'b0);
        quiet(1'b0);
        step(1'b1, 1'b1, 1'b1, 1'b1, TB_ID[0]);
        repeat (4) quiet(1'b1);
        check(80'(cur_instr), 80'(IR_BYPASS), "instruction in reset state");
        quiet(1'b0);
        codes = '{IR_BYPASS, IR_CLAMP, IR_HIGHZ, 8'h10 | 8'($urandom & 32'h0c), IR_EXTEST,
                  IR_SAMPLE, IR_SAMPLE_IN, IR_SAMPLE_OUT, IR_EXTEST_OUT};
        held = 80'(cells);
        foreach (codes[k])
        begin
            code = codes[k];
            is_bsr = (code == IR_EXTEST || code == IR_SAMPLE || code == IR_SAMPLE_IN ||
                      code == IR_SAMPLE_OUT || code == IR_EXTEST_OUT);
            load_ir(code, -1);
            check(80'(drive), 80'(code == IR_EXTEST || code == IR_CLAMP ||
                  code == IR_EXTEST_OUT), "latch drive");
            check(80'(highz), 80'(code == IR_HIGHZ), "forced off");
            sys_obs <= tbs_cells_t'(80'({$urandom, $urandom, $urandom}));
            din = 80'({$urandom, $urandom, $urandom});
            quiet(1'b0);
            quiet(1'b0);
            if (is_bsr)
            begin
                scan(1'b0, BSR_W, din, 80'(sys_obs), -1);
                check(80'(cells), din, "update latches");
                check(80'(cells.b_out), 80'(din[53:36]), "chain order");
                check(80'({a_en, b_en}), 80'({din[77], din[73], din[76], din[72]}),
                      "enable latches");
                held = din;
            end
            else
            begin
                scan(1'b0, 9, din, din << 1, -1);
                check(80'(cells), held, "unselected latches hold");
            end
        end
        // A stopped test clock changes nothing.
        repeat (300) @(posedge i_sys_clk);
        check(80'({cells, cur_instr}), 80'({held, IR_EXTEST_OUT}), "stopped clock");
        repeat (5) quiet(1'b1);
        check(80'({drive, cur_instr}), 80'({1'b0, IR_BYPASS}), "test logic off");
        for (int k = 0; k < 100 && exp_q.size() != 0; k++)
            @(posedge i_sys_clk);
        check(80'(exp_q.size()), 80'h0, "notes left over");
        report_and_stop();
    end

endmodule : tbs_tap_tb

// [testbench/tbs_tester_model.sv]
// Behavioural scan tester that drives the test pins and samples the serial output.
`timescale 1ns/100ps

module tbs_tester_model
    import tbs_pkg::*;
(
    // Clock used to pace the test pins
    input  wire logic         i_sys_clk,
    // Serial output from the device
    input  wire tbs_tap_out_t i_tap_out,
    // Test pins towards the device
    output tbs_tap_in_t       o_tap_in,
    // One-cycle pulse per test clock, with the two samples taken
    output logic              o_seen,
    output tbs_tap_out_t      o_before_rise,
    output tbs_tap_out_t      o_before_fall
);
    // ------------------------------------------------------------------
    // Test clock pacing: 40 system clocks make one 160 ns test clock.
    // ------------------------------------------------------------------
    localparam int LOW_LEAD  = 10; // Setup of mode and data before the rise.
    localparam int HIGH_CLKS = 20; // High half of the test clock.
    localparam int LOW_TAIL  = 8;  // Hold after the fall before release.

    // The test clock rests low between frames, and released lines float high.
    initial
    begin
        o_tap_in      = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
        o_seen        = 1'b0;
        o_before_rise = '0;
        o_before_fall = '0;
    end

    // One full test clock with the given mode select and data bits.
    // The output is read just before the rise, where a downstream part would sample it,
    // and again just before the fall, so that any change while high is exposed.
    task automatic tck_cycle(input logic tms, input logic tdi);
        @(posedge i_sys_clk);
        o_before_rise <= i_tap_out;
        o_tap_in.tms  <= tms;
        o_tap_in.tdi  <= tdi;
        repeat (LOW_LEAD) @(posedge i_sys_clk);
        o_tap_in.tck  <= 1'b1;
        repeat (HIGH_CLKS) @(posedge i_sys_clk);
        o_before_fall <= i_tap_out;
        o_tap_in.tck  <= 1'b0;
        repeat (LOW_TAIL) @(posedge i_sys_clk);
        // Lines released after their hold time fall back to the pull-up level.
        o_tap_in.tms  <= 1'b1;
        o_tap_in.tdi  <= 1'b1;
        o_seen        <= 1'b1;
        @(posedge i_sys_clk);
        o_seen        <= 1'b0;
    endtask : tck_cycle

endmodule : tbs_tester_model
